// ### src/rir_pkg.sv
// Shared constants and carrier types for the radio status and filter register bank
package rir_pkg;
	// Register bus geometry
	localparam int unsigned ADDR_W = 8;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	// Register indices; the byte address is four times the index
	localparam logic [7:0] IDX_FILL_CTRL = 8'h0e;
	localparam logic [7:0] IDX_LVL_THR = 8'h0f;
	localparam logic [7:0] IDX_RX_BW = 8'h10;
	localparam logic [7:0] IDX_IRQ_STAT = 8'h20;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
	localparam logic [7:0] IDX_MODE_CFG = 8'h22;

	// Reset values
	localparam logic [7:0] FILL_CTRL_RST = 8'h01;
	localparam logic [7:0] LVL_THR_RST = 8'h00;
	localparam logic [7:0] RX_BW_RST = 8'ha3;
	localparam logic [4:0] IRQ_MASK_RST = 5'h00;
	localparam logic [2:0] MODE_CFG_RST = 3'h0;

	// Fill and flag control bit positions
	localparam int unsigned FILL_MODE_BIT = 7;
	localparam int unsigned FILL_FLAG_BIT = 6;
	localparam int unsigned TX_DONE_BIT = 5;
	localparam int unsigned OVF_BIT = 4;
	localparam int unsigned LVL_EN_BIT = 3;
	localparam int unsigned LVL_FLAG_BIT = 2;
	localparam int unsigned LOCK_ST_BIT = 1;
	localparam int unsigned LOCK_EN_BIT = 0;

	// Bandwidth register fields
	localparam int unsigned LP_BW_MSB = 7;
	localparam int unsigned LP_BW_LSB = 4;
	localparam int unsigned CUTOFF_MSB = 3;
	localparam int unsigned CUTOFF_LSB = 0;

	// Interrupt status and mask bit positions
	localparam int unsigned EV_W = 5;
	localparam int unsigned EV_PATTERN = 0;
	localparam int unsigned EV_TX_DONE = 1;
	localparam int unsigned EV_OVERFLOW = 2;
	localparam int unsigned EV_LEVEL = 3;
	localparam int unsigned EV_LOCK = 4;

	// Mode configuration fields
	localparam int unsigned LINE_B_SEL_BIT = 2;

	typedef enum logic [1:0] {DM_CONT, DM_BUFF, DM_PKT, DM_RSVD} rir_dmode_type;

	typedef struct packed {
		logic pattern_seen;
		logic tx_shifting;
		logic tx_last_bit;
		logic fifo_overflow;
		logic transmitting;
		logic [7:0] rssi;
	} rir_rstat_type;

	typedef struct packed {
		logic fill_enable;
		logic fifo_clear;
		logic packet_restart;
		logic [3:0] lowpass_bw_code;
		logic [3:0] filter_cutoff_code;
		logic [7:0] level_threshold;
	} rir_rctl_type;

	function automatic logic [ADDR_W-1:0] byte_addr(input logic [7:0] idx);
		return {idx[5:0], 2'b00};
	endfunction : byte_addr
endpackage : rir_pkg

// ### src/rir_radio_irq_status_regs.sv
// Status, flag and receive filter register bank of the radio, AXI4-Lite slave
// Notes on behaviour
// R1: With fill mode 0, received data enters the FIFO only after the start pattern is recognized.
// R2: With fill mode 1, the FIFO fills while the fill flag is 1, which the host sets and clears.
// R3: With fill mode 0, pattern recognition raises the fill flag and a host write of 1 resets it.
// R4: The transmit-done bit reads 0 while bits go to the modulator and 1 after the last one.
// R5: In buffered mode a host write of 1 to the overflow bit empties the FIFO.
// R6: In packet mode that write also empties the FIFO and lets a new packet start at once.
// R7: The level enable bit gates signal-level detection and its interrupt.
// R8: The level flag sets when the measured strength is at or above the threshold.
// R9: The level flag stays set until the host writes 1 to it.
// R10: The lock-status bit latches on each synthesizer lock until the host writes 1 to it.
// R11: The lock pin is held high when its enable is 0 and follows live lock when it is 1.
// R12: An 8-bit threshold register, reset to zero, sets the level comparison point.
// R13: A 4-bit low-pass bandwidth code in bits 7 to 4 is stored and passed to the receiver.
// R14: A 4-bit filter cutoff code in bits 3 to 0, default 0011, drives the receive filters.
// R15: The fill and flag control register resets to 0x01, only the lock pin enable set.
// R16: In buffered or packet transmit, line B follows transmit-done when its select bit is 1.
// R17: The level comparison runs every cycle on the latest measurement, only while enabled.
`timescale 1ns/1ps
`default_nettype none
module rir_radio_irq_status_regs
	import rir_pkg::*;
(
	input wire logic CLK_SYS,
	input wire logic SRST,
	input wire logic [ADDR_W-1:0] AXI_AWADDR,
	input wire logic AXI_AWVALID,
	output logic AXI_AWREADY,
	input wire logic [31:0] AXI_WDATA,
	input wire logic [3:0] AXI_WSTRB,
	input wire logic AXI_WVALID,
	output logic AXI_WREADY,
	output logic [1:0] AXI_BRESP,
	output logic AXI_BVALID,
	input wire logic AXI_BREADY,
	input wire logic [ADDR_W-1:0] AXI_ARADDR,
	input wire logic AXI_ARVALID,
	output logic AXI_ARREADY,
	output logic [31:0] AXI_RDATA,
	output logic [1:0] AXI_RRESP,
	output logic AXI_RVALID,
	input wire logic AXI_RREADY,
	input wire rir_rstat_type RADIO_STAT,
	input wire logic SYNTH_LOCK,
	output rir_rctl_type RX_CTRL,
	output logic LOCK_PIN,
	output logic HOST_IRQ_B,
	output logic IRQ
);

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] idx);
		return a == byte_addr(idx);
	endfunction : hit

	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic aw_full_q;
	logic w_full_q;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [7:0] w_byte_q;
	logic w_lane_q;
	logic arready_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;

	logic fill_mode_q;
	logic start_det_q;
	logic tx_done_q;
	logic ovf_q;
	logic lvl_en_q;
	logic sov_q;
	logic lock_st_q;
	logic lock_en_q;
	logic [7:0] thr_q;
	logic [7:0] bw_q;
	logic [EV_W-1:0] irq_st_q;
	logic [EV_W-1:0] irq_mask_q;
	rir_dmode_type dmode_q;
	logic line_b_sel_q;
	logic lock_s1_q;
	logic lock_s2_q;
	logic lock_s3_q;
	rir_rctl_type rx_q;
	logic lock_pin_q;
	logic line_b_q;
	logic irq_q;

	logic wr_go;
	logic wr_hit;
	logic wr_fill;
	logic wr_thr;
	logic wr_bw;
	logic wr_mask;
	logic wr_mode;
	logic rd_go;
	logic rd_hit;
	logic [7:0] rd_byte;
	logic [7:0] fill_ctrl_rd;
	logic lvl_hit;
	logic lock_rise;
	logic clr_d;
	logic restart_d;
	logic [EV_W-1:0] ev;
	logic [EV_W-1:0] irq_st_d;

	// Write happens once address and data are both held and the last response is gone
	assign wr_go = aw_full_q & w_full_q & ~bvalid_q;
	assign wr_hit = hit(aw_addr_q, IDX_FILL_CTRL) | hit(aw_addr_q, IDX_LVL_THR)
		| hit(aw_addr_q, IDX_RX_BW) | hit(aw_addr_q, IDX_IRQ_STAT)
		| hit(aw_addr_q, IDX_IRQ_MASK) | hit(aw_addr_q, IDX_MODE_CFG);
	assign wr_fill = wr_go & w_lane_q & hit(aw_addr_q, IDX_FILL_CTRL);
	assign wr_thr = wr_go & w_lane_q & hit(aw_addr_q, IDX_LVL_THR);
	assign wr_bw = wr_go & w_lane_q & hit(aw_addr_q, IDX_RX_BW);
	assign wr_mask = wr_go & w_lane_q & hit(aw_addr_q, IDX_IRQ_MASK);
	assign wr_mode = wr_go & w_lane_q & hit(aw_addr_q, IDX_MODE_CFG);
	assign rd_go = AXI_ARVALID & arready_q;

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			awready_q <= 1'b1;
			aw_full_q <= 1'b0;
			aw_addr_q <= '0;
		end else begin
			if (AXI_AWVALID && awready_q) begin
				awready_q <= 1'b0;
				aw_full_q <= 1'b1;
				aw_addr_q <= AXI_AWADDR;
			end else if (wr_go) begin
				aw_full_q <= 1'b0;
			end
			if (bvalid_q && AXI_BREADY) begin
				awready_q <= 1'b1;
			end
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			wready_q <= 1'b1;
			w_full_q <= 1'b0;
			w_byte_q <= 8'h00;
			w_lane_q <= 1'b0;
		end else begin
			if (AXI_WVALID && wready_q) begin
				wready_q <= 1'b0;
				w_full_q <= 1'b1;
				w_byte_q <= AXI_WDATA[7:0];
				w_lane_q <= AXI_WSTRB[0];
			end else if (wr_go) begin
				w_full_q <= 1'b0;
			end
			if (bvalid_q && AXI_BREADY) begin
				wready_q <= 1'b1;
			end
		end
	end

	// Unmapped addresses answer SLVERR and change nothing
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (AXI_BREADY) begin
			bvalid_q <= 1'b0;
		end
	end

	assign fill_ctrl_rd = {fill_mode_q, start_det_q, tx_done_q, ovf_q,
		lvl_en_q, sov_q, lock_st_q, lock_en_q};

	always_comb begin
		rd_byte = 8'h00;
		rd_hit = 1'b1;
		if (hit(AXI_ARADDR, IDX_FILL_CTRL)) begin
			rd_byte = fill_ctrl_rd;
		end else if (hit(AXI_ARADDR, IDX_LVL_THR)) begin
			rd_byte = thr_q;
		end else if (hit(AXI_ARADDR, IDX_RX_BW)) begin
			rd_byte = bw_q;
		end else if (hit(AXI_ARADDR, IDX_IRQ_STAT)) begin
			rd_byte = {3'h0, irq_st_q};
		end else if (hit(AXI_ARADDR, IDX_IRQ_MASK)) begin
			rd_byte = {3'h0, irq_mask_q};
		end else if (hit(AXI_ARADDR, IDX_MODE_CFG)) begin
			rd_byte = {5'h00, line_b_sel_q, dmode_q};
		end else begin
			rd_hit = 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rresp_q <= RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end else if (rd_go) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			rdata_q <= {24'h00_0000, rd_byte};
		end else if (rvalid_q && AXI_RREADY) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
		end
	end

	// Plain read/write configuration
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			fill_mode_q <= FILL_CTRL_RST[FILL_MODE_BIT]; // R15
			lvl_en_q <= FILL_CTRL_RST[LVL_EN_BIT]; // R15
			lock_en_q <= FILL_CTRL_RST[LOCK_EN_BIT]; // R15
			thr_q <= LVL_THR_RST; // R12
			bw_q <= RX_BW_RST; // R14
			irq_mask_q <= IRQ_MASK_RST;
			dmode_q <= rir_dmode_type'(MODE_CFG_RST[1:0]);
			line_b_sel_q <= MODE_CFG_RST[LINE_B_SEL_BIT];
		end else begin
			if (wr_fill) begin
				fill_mode_q <= w_byte_q[FILL_MODE_BIT];
				lvl_en_q <= w_byte_q[LVL_EN_BIT];
				lock_en_q <= w_byte_q[LOCK_EN_BIT];
			end
			if (wr_thr) begin
				thr_q <= w_byte_q; // R12
			end
			if (wr_bw) begin
				bw_q <= w_byte_q; // R13 R14
			end
			if (wr_mask) begin
				irq_mask_q <= w_byte_q[EV_W-1:0];
			end
			if (wr_mode) begin
				dmode_q <= rir_dmode_type'(w_byte_q[1:0]);
				line_b_sel_q <= w_byte_q[LINE_B_SEL_BIT];
			end
		end
	end

	// Fill flag; a recognition in the clearing cycle wins so no pattern is lost
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			start_det_q <= FILL_CTRL_RST[FILL_FLAG_BIT];
		end else if (!fill_mode_q) begin
			if (RADIO_STAT.pattern_seen) begin
				start_det_q <= 1'b1; // R3
			end else if (wr_fill && w_byte_q[FILL_FLAG_BIT]) begin
				start_det_q <= 1'b0; // R3
			end
		end else if (wr_fill) begin
			start_det_q <= w_byte_q[FILL_FLAG_BIT]; // R2
		end
	end

	// Last bit beats a simultaneous shift so the done edge is not missed
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			tx_done_q <= FILL_CTRL_RST[TX_DONE_BIT];
		end else if (RADIO_STAT.tx_last_bit) begin
			tx_done_q <= 1'b1; // R4
		end else if (RADIO_STAT.tx_shifting) begin
			tx_done_q <= 1'b0; // R4
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			ovf_q <= FILL_CTRL_RST[OVF_BIT];
		end else begin
			ovf_q <= RADIO_STAT.fifo_overflow | (ovf_q & ~(wr_fill & w_byte_q[OVF_BIT]));
		end
	end

	assign lvl_hit = lvl_en_q & (RADIO_STAT.rssi >= thr_q); // R7 R8 R17

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			sov_q <= FILL_CTRL_RST[LVL_FLAG_BIT];
		end else begin
			sov_q <= lvl_hit | (sov_q & ~(wr_fill & w_byte_q[LVL_FLAG_BIT])); // R9
		end
	end

	// Lock comes from the analog synthesizer, so it is synchronised first
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			lock_s1_q <= 1'b0;
			lock_s2_q <= 1'b0;
			lock_s3_q <= 1'b0;
		end else begin
			lock_s1_q <= SYNTH_LOCK;
			lock_s2_q <= lock_s1_q;
			lock_s3_q <= lock_s2_q;
		end
	end

	assign lock_rise = lock_s2_q & ~lock_s3_q;

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			lock_st_q <= FILL_CTRL_RST[LOCK_ST_BIT];
		end else begin
			lock_st_q <= lock_rise | (lock_st_q & ~(wr_fill & w_byte_q[LOCK_ST_BIT])); // R10
		end
	end

	// FIFO clear only means something where a FIFO is in use
	always_comb begin
		clr_d = 1'b0;
		restart_d = 1'b0;
		if (wr_fill && w_byte_q[OVF_BIT]) begin
			case (dmode_q)
				DM_BUFF: begin
					clr_d = 1'b1; // R5
				end
				DM_PKT: begin
					clr_d = 1'b1; // R6
					restart_d = 1'b1; // R6
				end
				default: begin
					clr_d = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			rx_q <= '0;
		end else begin
			rx_q.fill_enable <= start_det_q; // R1 R2
			rx_q.fifo_clear <= clr_d;
			rx_q.packet_restart <= restart_d;
			rx_q.lowpass_bw_code <= bw_q[LP_BW_MSB:LP_BW_LSB]; // R13
			rx_q.filter_cutoff_code <= bw_q[CUTOFF_MSB:CUTOFF_LSB]; // R14
			rx_q.level_threshold <= thr_q; // R12
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			lock_pin_q <= 1'b1;
			line_b_q <= 1'b0;
		end else begin
			lock_pin_q <= lock_en_q ? lock_s2_q : 1'b1; // R11
			line_b_q <= RADIO_STAT.transmitting & line_b_sel_q
				& ((dmode_q == DM_BUFF) | (dmode_q == DM_PKT)) & tx_done_q; // R16
		end
	end

	// Interrupt status clears on read; an event in the read cycle stays pending
	always_comb begin
		ev = '0;
		ev[EV_PATTERN] = RADIO_STAT.pattern_seen & ~fill_mode_q;
		ev[EV_TX_DONE] = RADIO_STAT.tx_last_bit & ~tx_done_q;
		ev[EV_OVERFLOW] = RADIO_STAT.fifo_overflow & ~ovf_q;
		ev[EV_LEVEL] = lvl_hit & ~sov_q; // R7
		ev[EV_LOCK] = lock_rise;
		irq_st_d = irq_st_q;
		if (rd_go && hit(AXI_ARADDR, IDX_IRQ_STAT)) begin
			irq_st_d = '0;
		end
		irq_st_d = irq_st_d | ev;
	end

	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			irq_st_q <= '0;
			irq_q <= 1'b0;
		end else begin
			irq_st_q <= irq_st_d;
			irq_q <= |(irq_st_q & irq_mask_q);
		end
	end

	assign AXI_AWREADY = awready_q;
	assign AXI_WREADY = wready_q;
	assign AXI_BVALID = bvalid_q;
	assign AXI_BRESP = bresp_q;
	assign AXI_ARREADY = arready_q;
	assign AXI_RVALID = rvalid_q;
	assign AXI_RRESP = rresp_q;
	assign AXI_RDATA = rdata_q;
	assign RX_CTRL = rx_q;
	assign LOCK_PIN = lock_pin_q;
	assign HOST_IRQ_B = line_b_q;
	assign IRQ = irq_q;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SRST);

	fill_wait_a: assert property (!fill_mode_q && !start_det_q && !RADIO_STAT.pattern_seen // R1
		|=> ##1 !RX_CTRL.fill_enable) else $error("fill started before pattern");
	fill_follow_a: assert property (fill_mode_q && wr_fill // R2
		|=> ##1 RX_CTRL.fill_enable == $past(w_byte_q[FILL_FLAG_BIT], 2))
		else $error("fill flag write not followed");
	pattern_set_a: assert property (!fill_mode_q && RADIO_STAT.pattern_seen // R3
		|=> start_det_q ##1 RX_CTRL.fill_enable) else $error("pattern did not set fill");
	tx_busy_a: assert property (RADIO_STAT.tx_shifting && !RADIO_STAT.tx_last_bit // R4
		|=> !fill_ctrl_rd[TX_DONE_BIT]) else $error("done while shifting");
	buf_clear_a: assert property (wr_fill && w_byte_q[OVF_BIT] && dmode_q == DM_BUFF // R5
		|=> RX_CTRL.fifo_clear && !RX_CTRL.packet_restart) else $error("no buffered clear");
	pkt_restart_a: assert property (wr_fill && w_byte_q[OVF_BIT] && dmode_q == DM_PKT // R6
		|=> RX_CTRL.fifo_clear && RX_CTRL.packet_restart) else $error("no packet restart");
	level_gate_a: assert property (!lvl_en_q && !sov_q && !wr_fill // R7
		|=> !sov_q) else $error("level flag set while disabled");
	level_set_a: assert property (lvl_en_q && RADIO_STAT.rssi >= thr_q // R8
		|=> sov_q) else $error("level flag missed");
	level_hold_a: assert property (sov_q && !(wr_fill && w_byte_q[LVL_FLAG_BIT]) // R9
		|=> sov_q) else $error("level flag dropped");
	lock_latch_a: assert property ($rose(lock_s2_q) // R10
		|=> lock_st_q) else $error("lock not latched");
	lock_pin_a: assert property (!lock_en_q |=> LOCK_PIN) else $error("lock pin not high"); // R11
	reset_ctrl_a: assert property ($fell(SRST) |-> fill_ctrl_rd == FILL_CTRL_RST // R15
		&& bw_q == RX_BW_RST && thr_q == LVL_THR_RST) else $error("bad reset values");
	line_b_a: assert property (RADIO_STAT.transmitting && line_b_sel_q // R16
		&& (dmode_q == DM_BUFF || dmode_q == DM_PKT)
		|=> HOST_IRQ_B == $past(tx_done_q)) else $error("line b not following");
	read_clear_a: assert property (rd_go && hit(AXI_ARADDR, IDX_IRQ_STAT) && ev == '0
		|=> irq_st_q == '0 && AXI_RVALID) else $error("status not cleared on read");

	write_seen_c: cover property (wr_fill && w_byte_q[OVF_BIT] && dmode_q == DM_PKT);
	level_irq_c: cover property (lvl_hit ##[1:4] IRQ);
	fill_stop_c: cover property (fill_mode_q && RX_CTRL.fill_enable ##[1:20] !RX_CTRL.fill_enable);
endmodule : rir_radio_irq_status_regs
`default_nettype wire

// ### test/rir_radio_model.sv
// Behavioural model of the radio core that feeds the register bank
`timescale 1ns/1ps
`default_nettype none
module rir_radio_model
	import rir_pkg::*;
(
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic pat_req,
	input wire logic ovf_req,
	input wire logic tx_req,
	input wire logic [7:0] rssi_set,
	input wire logic lock_set,
	output rir_rstat_type radio_stat,
	output logic synth_lock
);
	logic pat_q;
	logic ovf_q;
	logic [4:0] tx_cnt_q;
	// Sixteen bit times, so that a bus read fits inside the shift phase
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			radio_stat <= '0;
			pat_q <= 1'b0;
			ovf_q <= 1'b0;
			tx_cnt_q <= 5'h10;
		end else begin
			pat_q <= pat_req;
			ovf_q <= ovf_req;
			radio_stat.pattern_seen <= pat_req & ~pat_q;
			radio_stat.fifo_overflow <= ovf_req & ~ovf_q;
			radio_stat.rssi <= rssi_set;
			radio_stat.transmitting <= tx_req;
			radio_stat.tx_shifting <= tx_req && tx_cnt_q > 5'h01;
			radio_stat.tx_last_bit <= tx_req && tx_cnt_q == 5'h01;
			if (!tx_req) begin
				tx_cnt_q <= 5'h10;
			end else if (tx_cnt_q != 5'h00) begin
				tx_cnt_q <= tx_cnt_q - 5'h01;
			end
		end
	end
	// Lock is asynchronous in the real part; the bank syncs it
	always_ff @(posedge clk_sys) begin
		synth_lock <= lock_set;
	end
endmodule : rir_radio_model
`default_nettype wire

// ### test/testbench.sv
// Self-checking bench for the radio status and filter register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import rir_pkg::*;
	localparam logic [7:0] A_CTL = 8'h38, A_THR = 8'h3c, A_BW = 8'h40;
	localparam logic [7:0] A_ST = 8'h80, A_MSK = 8'h84, A_MOD = 8'h88;
	logic clk = 1'b0, srst = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00, rssi_set = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic pat_req = 1'b0, ovf_req = 1'b0, tx_req = 1'b0, lock_set = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic awready, wready, bvalid, arready, rvalid, synth_lock, lock_pin, irq_b, irq;
	logic [1:0] bresp, rresp, r;
	logic [31:0] rdata;
	logic [7:0] t, v, b;
	rir_rstat_type radio_stat;
	rir_rctl_type rx_ctrl;
	int n_fail = 0, comparisons = 0, n_clr = 0, n_rst = 0, c0, r0;

	always #5 clk = ~clk;

	rir_radio_irq_status_regs uut (
		.CLK_SYS(clk), .SRST(srst), .AXI_AWADDR(awaddr), .AXI_AWVALID(awvalid),
		.AXI_AWREADY(awready), .AXI_WDATA(wdata), .AXI_WSTRB(4'h1), .AXI_WVALID(wvalid),
		.AXI_WREADY(wready), .AXI_BRESP(bresp), .AXI_BVALID(bvalid), .AXI_BREADY(bready),
		.AXI_ARADDR(araddr), .AXI_ARVALID(arvalid), .AXI_ARREADY(arready), .AXI_RDATA(rdata),
		.AXI_RRESP(rresp), .AXI_RVALID(rvalid), .AXI_RREADY(rready), .RADIO_STAT(radio_stat),
		.SYNTH_LOCK(synth_lock), .RX_CTRL(rx_ctrl), .LOCK_PIN(lock_pin), .HOST_IRQ_B(irq_b),
		.IRQ(irq)
	);
	rir_radio_model radio (
		.clk_sys(clk), .srst(srst), .pat_req(pat_req), .ovf_req(ovf_req), .tx_req(tx_req),
		.rssi_set(rssi_set), .lock_set(lock_set), .radio_stat(radio_stat), .synth_lock(synth_lock)
	);

	// Counted away from the rising edge to stay clear of the update race
	always @(negedge clk) begin
		if (rx_ctrl.fifo_clear === 1'b1) n_clr++;
		if (rx_ctrl.packet_restart === 1'b1) n_rst++;
	end

	function automatic logic lvl(input logic [7:0] thr, input logic [7:0] s);
		return s >= thr;
	endfunction : lvl

	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	task automatic guard(input int n);
		if (n > 40) begin
			n_fail++;
			$display("[FAIL] bus answer expected within 40 cycles seen none");
			summarize();
		end
	endtask : guard

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
		logic aw_t, w_t, b_t;
		int n;
		@(posedge clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= {24'h0, d};
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		b_t = 1'b0;
		while (!b_t) begin
			@(negedge clk);
			aw_t = awvalid && awready;
			w_t = wvalid && wready;
			b_t = bvalid === 1'b1;
			if (b_t) chk($sformatf("write resp %h", a), {6'h0, bresp}, {6'h0, er});
			@(posedge clk);
			if (aw_t) awvalid <= 1'b0;
			if (w_t) wvalid <= 1'b0;
			if (b_t) bready <= 1'b0;
			n++;
			guard(n);
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] rr);
		logic a_t, r_t;
		int n;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		r_t = 1'b0;
		while (!r_t) begin
			@(negedge clk);
			a_t = arvalid && arready;
			r_t = rvalid === 1'b1;
			d = rdata[7:0];
			rr = rresp;
			@(posedge clk);
			if (a_t) arvalid <= 1'b0;
			if (r_t) rready <= 1'b0;
			n++;
			guard(n);
		end
	endtask : rd

	task automatic rdc(input logic [7:0] a, input logic [7:0] e);
		rd(a, v, r);
		chk($sformatf("read %h", a), v, e);
		chk($sformatf("read resp %h", a), {6'h0, r}, {6'h0, RESP_OKAY});
	endtask : rdc

	initial begin
		void'($urandom(32'h132e6286));
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		cyc(2);
		chk("lowpass reset", {4'h0, rx_ctrl.lowpass_bw_code}, 8'h0a);
		chk("cutoff reset", {4'h0, rx_ctrl.filter_cutoff_code}, 8'h03);
		rdc(A_CTL, 8'h01);
		rdc(A_THR, 8'h00);
		rdc(A_BW, 8'ha3);
		rdc(A_ST, 8'h00);
		rdc(A_MSK, 8'h00);
		rdc(A_MOD, 8'h00);
		chk("lock pin live", {7'h0, lock_pin}, 8'h00);
		for (int i = 0; i < 16; i++) begin
			t = (i == 0) ? 8'hff : 8'($urandom);
			b = {4'(i), 4'($urandom)};
			wr(A_THR, t, RESP_OKAY);
			wr(A_BW, b, RESP_OKAY);
			rdc(A_THR, t);
			rdc(A_BW, b);
			chk("threshold out", rx_ctrl.level_threshold, t);
			chk("lowpass out", {4'h0, rx_ctrl.lowpass_bw_code}, {4'h0, b[7:4]});
			chk("cutoff out", {4'h0, rx_ctrl.filter_cutoff_code}, {4'h0, b[3:0]});
		end
		rd(8'h44, v, r);
		chk("unmapped data", v, 8'h00);
		chk("unmapped resp", {6'h0, r}, {6'h0, RESP_SLVERR});
		wr(8'h44, 8'hff, RESP_SLVERR);
		rdc(A_BW, b);
		chk("fill idle", {7'h0, rx_ctrl.fill_enable}, 8'h00);
		@(posedge clk) pat_req <= 1'b1;
		@(posedge clk) pat_req <= 1'b0;
		cyc(4);
		chk("fill on pattern", {7'h0, rx_ctrl.fill_enable}, 8'h01);
		rdc(A_CTL, 8'h41);
		wr(A_CTL, 8'h41, RESP_OKAY);
		cyc(2);
		chk("fill rearmed", {7'h0, rx_ctrl.fill_enable}, 8'h00);
		rdc(A_CTL, 8'h01);
		wr(A_CTL, 8'h81, RESP_OKAY);
		wr(A_CTL, 8'hc1, RESP_OKAY);
		cyc(2);
		chk("fill by host", {7'h0, rx_ctrl.fill_enable}, 8'h01);
		wr(A_CTL, 8'h81, RESP_OKAY);
		cyc(2);
		chk("fill stopped", {7'h0, rx_ctrl.fill_enable}, 8'h00);
		rdc(A_CTL, 8'h81);
		wr(A_CTL, 8'h01, RESP_OKAY);
		for (int m = 0; m < 3; m++) begin
			wr(A_MOD, 8'(m), RESP_OKAY);
			c0 = n_clr;
			r0 = n_rst;
			@(posedge clk) ovf_req <= 1'b1;
			@(posedge clk) ovf_req <= 1'b0;
			cyc(3);
			rdc(A_CTL, 8'h11);
			wr(A_CTL, 8'h11, RESP_OKAY);
			cyc(3);
			rdc(A_CTL, 8'h01);
			chk("clear pulses", 8'(n_clr - c0), {7'h0, m != 0});
			chk("restart pulses", 8'(n_rst - r0), {7'h0, m == 2});
		end
		for (int k = 0; k < 2; k++) begin
			t = (k == 0) ? 8'h01 : 8'(8'h02 + $urandom % 253);
			wr(A_THR, t, RESP_OKAY);
			wr(A_CTL, 8'h01, RESP_OKAY);
			@(posedge clk) rssi_set <= 8'hff;
			cyc(4);
			rdc(A_CTL, 8'h01);
			@(posedge clk) rssi_set <= t - 8'h01;
			cyc(2);
			wr(A_CTL, 8'h09, RESP_OKAY);
			cyc(4);
			rdc(A_CTL, {5'h01, lvl(t, t - 8'h01), 2'b01});
			@(posedge clk) rssi_set <= t;
			cyc(4);
			rdc(A_CTL, {5'h01, lvl(t, t), 2'b01});
			@(posedge clk) rssi_set <= 8'h00;
			cyc(4);
			rdc(A_CTL, 8'h0d);
			wr(A_CTL, 8'h0d, RESP_OKAY);
			rdc(A_CTL, 8'h09);
		end
		rd(A_ST, v, r);
		wr(A_MSK, 8'h08, RESP_OKAY);
		cyc(2);
		chk("irq idle", {7'h0, irq}, 8'h00);
		@(posedge clk) rssi_set <= 8'hff;
		cyc(5);
		chk("irq level", {7'h0, irq}, 8'h01);
		rdc(A_ST, 8'h08);
		cyc(2);
		chk("irq after read", {7'h0, irq}, 8'h00);
		@(posedge clk) pat_req <= 1'b1;
		@(posedge clk) pat_req <= 1'b0;
		cyc(4);
		chk("irq masked", {7'h0, irq}, 8'h00);
		rdc(A_ST, 8'h01);
		@(posedge clk) rssi_set <= 8'h00;
		wr(A_CTL, 8'h45, RESP_OKAY);
		@(posedge clk) lock_set <= 1'b1;
		cyc(8);
		rdc(A_CTL, 8'h03);
		chk("lock pin high", {7'h0, lock_pin}, 8'h01);
		@(posedge clk) lock_set <= 1'b0;
		cyc(8);
		rdc(A_CTL, 8'h03);
		chk("lock pin low", {7'h0, lock_pin}, 8'h00);
		wr(A_CTL, 8'h02, RESP_OKAY);
		cyc(2);
		rdc(A_CTL, 8'h00);
		chk("lock pin off", {7'h0, lock_pin}, 8'h01);
		wr(A_CTL, 8'h01, RESP_OKAY);
		wr(A_MOD, 8'h05, RESP_OKAY);
		@(posedge clk) tx_req <= 1'b1;
		cyc(2);
		rdc(A_CTL, 8'h01);
		chk("line b shifting", {7'h0, irq_b}, 8'h00);
		cyc(20);
		rdc(A_CTL, 8'h21);
		chk("line b done", {7'h0, irq_b}, 8'h01);
		wr(A_MOD, 8'h01, RESP_OKAY);
		cyc(2);
		chk("line b deselected", {7'h0, irq_b}, 8'h00);
		summarize();
	end
endmodule : testbench
`default_nettype wire
